// ---- rtl/hpe_pkg.sv ----
`default_nettype none

package hpe_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NPORT    = 2;   // Downstream ports with a slot
   localparam int NFLAG    = 5;   // Slot event flags per port

   // ----------------------------------------------------------------
   // Flag positions in slot status and slot control
   // ----------------------------------------------------------------
   localparam int BTN_BIT  = 0;   // Button pressed
   localparam int PWRF_BIT = 1;   // Power fault
   localparam int LATCH_BIT = 2;  // Latch sensor changed
   localparam int PRES_BIT = 3;   // Presence changed
   localparam int CMDD_BIT = 4;   // Command done
   localparam int HOTPLUG_IRQ_ENABLE_BIT = 5;   // Global hot-plug irq enable in slot control

   // Port command word field positions
   localparam int LEGACY_IRQ_DISABLE_BIT = 0;  // Legacy irq disable
   localparam int MSIEN_BIT = 1;  // MSI enable
   localparam int PD3_BIT   = 2;  // Port in D3hot

   // Switch word field positions
   localparam int SWD3_BIT  = 0;  // Whole switch in D3hot
   localparam int ALT7_BIT  = 1;  // GPIO 7 alternate function

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] PORT_STRIDE = 8'h10;  // Per-port block size
   localparam logic [7:0] SLOT_CTL_OFS = 8'h00; // slot_control_reg
   localparam logic [7:0] SLOT_STS_OFS = 8'h04; // slot_status_reg
   localparam logic [7:0] CMD_OFS      = 8'h08; // command_reg and MSI enable
   localparam logic [7:0] GEV_CTL_OFS  = 8'h20; // general_event_control_reg
   localparam logic [7:0] GEV_STS_OFS  = 8'h24; // general_event_status_reg
   localparam logic [7:0] SW_CFG_OFS   = 8'h28; // Switch power state and pin mux

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [5:0]  SLOT_CTL_RST = 6'h00;
   localparam logic [2:0]  CMD_RST      = 3'h0;
   localparam logic [NPORT-1:0] GEV_CTL_RST = 2'h0;
   localparam logic [1:0]  SW_CFG_RST   = 2'h0;

   // Defaults loaded from the serial configuration memory
   typedef struct packed {
      logic             msi_en;  // MSI enable
      logic             legacy_irq_disable;   // Legacy irq disable
      logic             hotplug_irq_enable;    // Hot-plug irq enable
      logic [NFLAG-1:0] en;      // Per-flag enables
      logic             gev;     // Use general-purpose events
   } hpe_port_cfg_t;

   // Bus slave states
   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_RDWAIT = 2'b10
   } hpe_bus_t;

endpackage : hpe_pkg

`default_nettype wire

// ---- rtl/hpe_signal.sv ----
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module hpe_signal
   import hpe_pkg::*;
(
   input  wire logic                  REF_CLK,        // 20 MHz core clock
   input  wire logic                  RST,            // Sync reset, high
   // AHB-Lite slave
   input  wire logic                  HSEL,
   input  wire logic [7:0]            HADDR,
   input  wire logic [1:0]            HTRANS,
   input  wire logic                  HWRITE,
   input  wire logic [2:0]            HSIZE,
   input  wire logic [31:0]           HWDATA,
   input  wire logic                  HREADY,
   output logic                       HREADYOUT,
   output logic [31:0]                HRDATA,
   output logic                       HRESP,
   // Configuration memory load
   input  wire logic                  CFG_LOAD,       // One-cycle load strobe
   input  wire hpe_port_cfg_t [NPORT-1:0] CFG_DATA,   // Per-port defaults
   // Slot event sources, one-cycle set pulses
   input  wire logic [NPORT-1:0][NFLAG-1:0] SLOT_EVT,
   // Signalling towards the root
   output logic [NPORT-1:0]           MSI_REQ,        // MSI send pulse
   output logic [NPORT-1:0]           INTX,           // Legacy irq level
   output logic [NPORT-1:0]           PME_REQ,        // Wake message pulse
   output logic                       GEN_EVENT,      // general_event_out
   output logic                       GPIO7_OUT,
   output logic                       GPIO7_OE
);

   // All checks below run on the core clock and sleep in reset
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   // Control state comes from the configuration memory or from bus
   // writes; the memory load wins a tie since it only runs at start-up
   logic [NPORT-1:0][5:0]       slot_ctl;     // Enables plus hot-plug enable
   logic [NPORT-1:0][NFLAG-1:0] slot_sts;     // Sticky slot flags
   logic [NPORT-1:0][2:0]       cmd;          // Legacy disable, MSI, D3hot
   logic [NPORT-1:0]            gev_ctl;      // General-event select
   logic [NPORT-1:0]            gev_sts;      // General-event status
   logic [1:0]                  sw_cfg;       // Switch D3hot, pin mux

   // Bus tracking
   hpe_bus_t    bus_st;                       // Read wait machine
   logic        wr_pend;                      // Write data phase due
   logic [7:0]  wr_addr;                      // Latched write address
   logic [7:0]  rd_addr;                      // Latched read address
   logic        addr_ok;                      // Valid address phase
   logic [31:0] rd_mux;                       // Read data selection

   // Per-port write-one-to-clear masks and general-event set terms
   logic [NPORT-1:0][NFLAG-1:0] sts_clr;
   logic [NPORT-1:0]            gev_clr;
   logic [NPORT-1:0]            gev_set;

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   // Writes take no wait; reads take one so the read mux sees any
   // write whose data phase overlaps the read address phase.
   assign addr_ok   = HSEL & HTRANS[1] & HREADY;
   assign HREADYOUT = (bus_st != BUS_RDWAIT);
   // Every offset completes; unmapped ones read zero, so no error
   assign HRESP     = 1'b0;

   // Read wait machine and address capture
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         bus_st  <= BUS_IDLE;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         rd_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_ok & HWRITE;
         if (addr_ok)
         begin
            wr_addr <= HADDR;
            rd_addr <= HADDR;
         end
         case (bus_st)
            BUS_IDLE:
               // Reads enter one wait cycle
               if (addr_ok && !HWRITE)
                  bus_st <= BUS_RDWAIT;
            BUS_RDWAIT:
               bus_st <= BUS_IDLE;
            default:
               bus_st <= BUS_IDLE;
         endcase
      end
   end

   // Read data selection; unmapped offsets read zero
   // Later matches would override earlier ones; the map has no overlap
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      for (int p = 0; p < NPORT; p++)
      begin
         if (rd_addr == 8'(p) * PORT_STRIDE + SLOT_CTL_OFS)
            rd_mux = {26'h0, slot_ctl[p]};
         if (rd_addr == 8'(p) * PORT_STRIDE + SLOT_STS_OFS)
            rd_mux = {27'h0, slot_sts[p]};
         if (rd_addr == 8'(p) * PORT_STRIDE + CMD_OFS)
            rd_mux = {29'h0, cmd[p]};
      end
      if (rd_addr == GEV_CTL_OFS)
         rd_mux = {30'h0, gev_ctl};
      if (rd_addr == GEV_STS_OFS)
         rd_mux = {30'h0, gev_sts};
      if (rd_addr == SW_CFG_OFS)
         rd_mux = {30'h0, sw_cfg};
   end

   // Read data register, loaded in the wait cycle
   // Holds until the next read's wait cycle, so a slow master keeps it
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         HRDATA <= 32'h0000_0000;
      else if (bus_st == BUS_RDWAIT)
         HRDATA <= rd_mux;
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // A configuration load only touches control state, never the
   // flags, so command done is not raised by it.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         slot_ctl <= {NPORT{SLOT_CTL_RST}};
         cmd      <= {NPORT{CMD_RST}};
         gev_ctl  <= GEV_CTL_RST;
         sw_cfg   <= SW_CFG_RST;
      end
      else if (CFG_LOAD)
      begin
         for (int p = 0; p < NPORT; p++)
         begin
            slot_ctl[p] <= {CFG_DATA[p].hotplug_irq_enable, CFG_DATA[p].en};
            cmd[p]      <= {cmd[p][PD3_BIT], CFG_DATA[p].msi_en, CFG_DATA[p].legacy_irq_disable};
            gev_ctl[p]  <= CFG_DATA[p].gev;
         end
      end
      else if (wr_pend)
      begin
         for (int p = 0; p < NPORT; p++)
         begin
            if (wr_addr == 8'(p) * PORT_STRIDE + SLOT_CTL_OFS)
               slot_ctl[p] <= HWDATA[5:0];
            if (wr_addr == 8'(p) * PORT_STRIDE + CMD_OFS)
               cmd[p] <= HWDATA[2:0];
         end
         if (wr_addr == GEV_CTL_OFS)
            gev_ctl <= HWDATA[NPORT-1:0];
         if (wr_addr == SW_CFG_OFS)
            sw_cfg <= HWDATA[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Per-port event path
   // ----------------------------------------------------------------
   for (genvar p = 0; p < NPORT; p++)
   begin : g_port
      logic [NFLAG-1:0] fresh;      // Flags newly set this cycle
      logic [NFLAG-1:0] live;       // Fresh flags passing own enable
      logic [NFLAG-1:0] wake_msk;   // Flags allowed to wake
      logic             hotplug_irq_enable;       // Hot-plug irq enable
      logic             in_d3;      // Port or switch in D3hot

      // Only a flag going from clear to set counts as an event, so a
      // source that repeats its pulse on a set flag cannot flood the
      // root; an event in the cycle of its own clear is not signalled

      assign hotplug_irq_enable     = slot_ctl[p][HOTPLUG_IRQ_ENABLE_BIT];
      assign fresh    = SLOT_EVT[p] & ~slot_sts[p];
      assign live     = fresh & slot_ctl[p][NFLAG-1:0];
      assign wake_msk = ~(NFLAG'(1) << CMDD_BIT);
      assign in_d3    = cmd[p][PD3_BIT] | sw_cfg[SWD3_BIT];
      assign sts_clr[p] = (wr_pend && wr_addr == 8'(p) * PORT_STRIDE + SLOT_STS_OFS)
                          ? HWDATA[NFLAG-1:0] : '0;
      assign gev_set[p] = gev_ctl[p] & (|live);

      // Sticky flags, same in both signalling modes; set beats clear
      always_ff @(posedge REF_CLK)
      begin
         if (RST)
            slot_sts[p] <= '0;
         else
            slot_sts[p] <= (slot_sts[p] & ~sts_clr[p]) | SLOT_EVT[p];
      end

      // In-band signalling, silenced for a general-event port
      // INTx is a level the root watches; MSI and wake are pulses it counts
      always_ff @(posedge REF_CLK)
      begin
         if (RST)
         begin
            MSI_REQ[p] <= 1'b0;
            INTX[p]    <= 1'b0;
            PME_REQ[p] <= 1'b0;
         end
         else
         begin
            // Pulse per fresh unmasked event
            MSI_REQ[p] <= !gev_ctl[p] && hotplug_irq_enable && cmd[p][MSIEN_BIT] && (|live);
            // Level while any enabled flag stays set
            INTX[p] <= !gev_ctl[p] && hotplug_irq_enable && !cmd[p][MSIEN_BIT] && !cmd[p][LEGACY_IRQ_DISABLE_BIT]
                       && (|(slot_sts[p] & slot_ctl[p][NFLAG-1:0]));
            // Wake regardless of hotplug_irq_enable in D3hot
            PME_REQ[p] <= !gev_ctl[p] && in_d3 && (|(live & wake_msk));
         end
      end
   end

   // ----------------------------------------------------------------
   // General-purpose event status and output
   // ----------------------------------------------------------------
   assign gev_clr = (wr_pend && wr_addr == GEV_STS_OFS) ? HWDATA[NPORT-1:0] : '0;

   // Sticky per-port status; set beats clear
   // A port outside general-event mode never drives gev_set, so its
   // status bit can only be cleared there, never set
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         gev_sts <= '0;
      else
         gev_sts <= (gev_sts & ~gev_clr) | gev_set;
   end

   // Shared event output follows status; only hot-plug terms feed it
   // Level output: stays up until software clears every status bit
   assign GEN_EVENT = |gev_sts;

   // Pin drivers are off in reset; the reset is synchronous, so a pin
   // with no clock keeps its last enable even while the board holds reset.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         GPIO7_OE  <= 1'b0;
         GPIO7_OUT <= 1'b0;
      end
      else
      begin
         GPIO7_OE  <= sw_cfg[ALT7_BIT];
         GPIO7_OUT <= sw_cfg[ALT7_BIT] & (|(gev_sts & ~gev_clr) | (|gev_set));
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Helper terms keep each property to one line; port 0 carries the
   // interrupt checks and port 1 the wake checks, but the command-done wake check is on port 0
   logic msi_due;                             // Port 0 owes an MSI
   logic intx_due;                            // Port 0 owes its INTx level
   logic mask_evt;                            // Port 0 sees only masked events
   logic wake_due;                            // Port 1 owes a wake
   logic both_due;                            // Port 1 owes a wake and an MSI
   logic load_quiet;                          // Load with command done clear

   assign msi_due    = !gev_ctl[0] && slot_ctl[0][HOTPLUG_IRQ_ENABLE_BIT] && cmd[0][MSIEN_BIT] && (|g_port[0].live);
   assign intx_due   = !gev_ctl[0] && slot_ctl[0][HOTPLUG_IRQ_ENABLE_BIT] && !cmd[0][MSIEN_BIT] && !cmd[0][LEGACY_IRQ_DISABLE_BIT]
                       && (|(slot_sts[0] & slot_ctl[0][NFLAG-1:0]));
   assign mask_evt   = (SLOT_EVT[0] != '0) && ((SLOT_EVT[0] & slot_ctl[0][NFLAG-1:0]) == '0);
   assign wake_due   = sw_cfg[SWD3_BIT] && !gev_ctl[1] && (|(g_port[1].live & 5'h0F));
   assign both_due   = wake_due && slot_ctl[1][HOTPLUG_IRQ_ENABLE_BIT] && cmd[1][MSIEN_BIT];
   assign load_quiet = CFG_LOAD && !SLOT_EVT[0][CMDD_BIT] && !slot_sts[0][CMDD_BIT];

   // Interrupt delivery
   msi_fresh_a:  assert property (msi_due |=> MSI_REQ[0])
      else $error("MSI missing");
   msi_hotplug_irq_enable_a:   assert property (!slot_ctl[0][HOTPLUG_IRQ_ENABLE_BIT] |=> !MSI_REQ[0])
      else $error("MSI without enable");
   intx_msi_a:   assert property (MSI_REQ[0] |-> $past(!INTX[0] || !cmd[0][MSIEN_BIT]))
      else $error("INTx with MSI");
   intx_level_a: assert property (intx_due |=> INTX[0])
      else $error("INTx missing");
   mask_quiet_a: assert property (mask_evt |=> !MSI_REQ[0] && !PME_REQ[0])
      else $error("masked event signalled");

   // Wake messages
   pme_d3_a:     assert property (wake_due |=> PME_REQ[1])
      else $error("wake missing");
   pme_both_a:   assert property (both_due |=> PME_REQ[1] && MSI_REQ[1])
      else $error("wake or MSI missing");
   pme_cmd_a:    assert property ((SLOT_EVT[0] == 5'h10) |=> !PME_REQ[0])
      else $error("command done woke");

   // General-purpose events and pin
   gev_quiet_a:  assert property (gev_ctl[1] |=> !MSI_REQ[1] && !PME_REQ[1] && !INTX[1])
      else $error("in-band while general");
   gev_only_a:   assert property ((!gev_ctl[0] && !gev_clr[0] && !gev_sts[0]) |=> !gev_sts[0])
      else $error("status set outside mode");
   gev_hold_a:   assert property ((gev_sts[0] && !gev_clr[0]) |=> GEN_EVENT)
      else $error("event output dropped");
   pin_alt_a:    assert property (!sw_cfg[ALT7_BIT] |=> !GPIO7_OE && !GPIO7_OUT)
      else $error("pin driven without alt");

   // Slot flags
   sts_keep_a:   assert property (SLOT_EVT[1][PRES_BIT] |=> slot_sts[1][PRES_BIT])
      else $error("flag lost");
   load_cc_a:    assert property (load_quiet |=> !slot_sts[0][CMDD_BIT])
      else $error("load set done flag");

   // Main scenarios seen
   msi_sent_c: cover property (MSI_REQ[0]);
   pme_both_c: cover property (PME_REQ[1] && slot_ctl[1][HOTPLUG_IRQ_ENABLE_BIT]);
   gev_pin_c:  cover property (GPIO7_OUT && GPIO7_OE);
   intx_on_c:  cover property (INTX[1]);

endmodule : hpe_signal

`default_nettype wire

// ---- sim/hpe_root_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module hpe_root_model
   import hpe_pkg::*;
(
   input  wire logic                 ref_clk,   // Core clock
   input  wire logic                 rst,       // Sync reset, high
   input  wire logic [NPORT-1:0]     msi_req,   // MSI send pulses
   input  wire logic [NPORT-1:0]     pme_req,   // Wake message pulses
   output var  logic [NPORT-1:0][7:0] msi_cnt,  // MSIs received per port
   output var  logic [NPORT-1:0][7:0] pme_cnt   // Wakes received per port
);

   // ----------------------------------------------------------------
   // Message counters
   // ----------------------------------------------------------------
   // Root accepts every message at once; counting keeps each pulse seen
   always_ff @(posedge ref_clk)
   begin
      for (int p = 0; p < NPORT; p++)
      begin
         if (rst)
         begin
            msi_cnt[p] <= 8'h00;
            pme_cnt[p] <= 8'h00;
         end
         else
         begin
            msi_cnt[p] <= msi_cnt[p] + 8'(msi_req[p]);
            pme_cnt[p] <= pme_cnt[p] + 8'(pme_req[p]);
         end
      end
   end

endmodule : hpe_root_model

`default_nettype wire

// ---- sim/hotplug_event_signalling_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module hotplug_event_signalling_tb
   import hpe_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic REF_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, CFG_LOAD;
   logic GEN_EVENT, GPIO7_OUT, GPIO7_OE;
   logic [7:0] HADDR;
   logic [1:0] HTRANS;
   logic [31:0] HWDATA, HRDATA, r;
   hpe_port_cfg_t [NPORT-1:0] CFG_DATA;
   logic [NPORT-1:0][NFLAG-1:0] SLOT_EVT;
   logic [NPORT-1:0] MSI_REQ, INTX, PME_REQ;
   logic [NPORT-1:0][7:0] msi_cnt, pme_cnt;
   logic [7:0] base, m0, q0;  // Port base, counts before event
   logic [3:0] e;             // Expected msi, intx, pme, gev
   logic en, hp, ms, xd, d3, sd, gv, alt;
   int fails, check_count, cyc, p, f;
   integer seed;

   hpe_signal u_dut (.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
      .HRDATA(HRDATA), .HRESP(HRESP), .CFG_LOAD(CFG_LOAD), .CFG_DATA(CFG_DATA), .SLOT_EVT(SLOT_EVT),
      .MSI_REQ(MSI_REQ), .INTX(INTX), .PME_REQ(PME_REQ), .GEN_EVENT(GEN_EVENT),
      .GPIO7_OUT(GPIO7_OUT), .GPIO7_OE(GPIO7_OE));

   hpe_root_model u_root (.ref_clk(REF_CLK), .rst(RST), .msi_req(MSI_REQ), .pme_req(PME_REQ),
      .msi_cnt(msi_cnt), .pme_cnt(pme_cnt));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask : chk

   // One single AHB transfer; waits on the slave, never on a fixed count
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      HSEL   <= 1'b1;
      HTRANS <= 2'b10;
      HADDR  <= a;
      HWRITE <= w;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      HSEL   <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      r = HRDATA;
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      bus(1'b0, a, 32'h0);
      chk("register", x, r);
   endtask : rd

   // Flag set pulse, one cycle wide
   task automatic pulse(input int pp, input int ff);
      @(posedge REF_CLK) SLOT_EVT[pp][ff] <= 1'b1;
      @(posedge REF_CLK) SLOT_EVT <= '0;
   endtask : pulse

   task automatic summarize();
      if (fails == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   // Expected root messages and event status for one flag pulse
   function automatic logic [3:0] hpe_expect(input logic n, h, m, x, d, g, c);
      hpe_expect[3] = !g && n && h && m;
      hpe_expect[2] = !g && n && h && !m && !x;
      hpe_expect[1] = !g && n && d && !c;
      hpe_expect[0] = g && n;
   endfunction : hpe_expect

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial
   begin
      REF_CLK = 1'b0;
      forever #25 REF_CLK = ~REF_CLK;
   end

   // Whole run needs about 1600 cycles; over twelve times that means a hang
   always @(posedge REF_CLK)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      seed = 32'hc0fa;
      {RST, HSEL, HWRITE, CFG_LOAD, HADDR, HTRANS, HWDATA, CFG_DATA, SLOT_EVT} = '0;
      RST = 1'b1;
      repeat (2) @(posedge REF_CLK);
      chk("outputs in reset", 32'h0, {GPIO7_OE, GEN_EVENT, MSI_REQ, INTX, PME_REQ});
      RST <= 1'b0;
      // Reset values, unmapped place reads zero
      for (int i = 0; i < 7; i++)
         rd(8'(i * 4 + (i > 2 ? 20 : 0)), 32'h0);
      rd(8'h3C, 32'h0);
      // Defaults from configuration memory, flags untouched
      @(posedge REF_CLK) CFG_DATA <= (2 * $bits(hpe_port_cfg_t))'($random(seed));
      CFG_LOAD <= 1'b1;
      @(posedge REF_CLK) CFG_LOAD <= 1'b0;
      for (p = 0; p < NPORT; p++)
      begin
         base = p ? PORT_STRIDE : 8'h00;
         rd(base + SLOT_CTL_OFS, 32'({CFG_DATA[p].hotplug_irq_enable, CFG_DATA[p].en}));
         rd(base + CMD_OFS, 32'({CFG_DATA[p].msi_en, CFG_DATA[p].legacy_irq_disable}));
         rd(base + SLOT_STS_OFS, 32'h0);
      end
      rd(GEV_CTL_OFS, 32'({CFG_DATA[1].gev, CFG_DATA[0].gev}));
      // Random modes; first five pulses cover every flag enabled
      for (int i = 0; i < 60; i++)
      begin
         r = $random(seed);
         {alt, gv, sd, d3, xd, ms, hp, en} = r[7:0];
         p = int'(r[8]);
         f = (i < 5) ? i : int'(r[15:12]) % 5;
         en = en | (i < 5);
         base = p ? PORT_STRIDE : 8'h00;
         bus(1'b1, base + SLOT_CTL_OFS, 32'({hp, 5'(en) << f}));
         bus(1'b1, base + CMD_OFS, 32'({d3, ms, xd}));
         bus(1'b1, GEV_CTL_OFS, 32'(gv) << p);
         bus(1'b1, SW_CFG_OFS, 32'({alt, sd}));
         m0 = msi_cnt[p];
         q0 = pme_cnt[p];
         pulse(p, f);
         repeat (3) @(posedge REF_CLK);
         e = hpe_expect(en, hp, ms, xd, d3 | sd, gv, f == CMDD_BIT);
         chk("msi_req", 32'(e[3]), 32'(msi_cnt[p] - m0));
         chk("intx", 32'(e[2]), 32'(INTX[p]));
         chk("pme_req", 32'(e[1]), 32'(pme_cnt[p] - q0));
         chk("gen_event", 32'(e[0]), 32'(GEN_EVENT));
         chk("gpio7", 32'(e[0] & alt), 32'(GPIO7_OUT));
         rd(base + SLOT_STS_OFS, 32'h1 << f);
         rd(GEV_STS_OFS, 32'(e[0]) << p);
         bus(1'b1, base + SLOT_STS_OFS, 32'h1F);
         bus(1'b1, GEV_STS_OFS, 32'h3);
         repeat (2) @(posedge REF_CLK);
         chk("intx cleared", 32'h0, 32'(INTX[p]));
         chk("gen_event cleared", 32'h0, 32'(GEN_EVENT));
      end
      // Second reset while the pin drives a pending event
      bus(1'b1, SW_CFG_OFS, 32'h2);
      bus(1'b1, GEV_CTL_OFS, 32'h1);
      bus(1'b1, SLOT_CTL_OFS, 32'h1);
      pulse(0, BTN_BIT);
      repeat (2) @(posedge REF_CLK);
      chk("gpio7 driving", 32'h1, 32'(GPIO7_OE & GPIO7_OUT));
      RST <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      chk("pin in reset", 32'h0, 32'({GPIO7_OE, GEN_EVENT}));
      RST <= 1'b0;
      rd(GEV_CTL_OFS, 32'h0);
      summarize();
   end

endmodule : hotplug_event_signalling_tb

`default_nettype wire
